// ===== common/sbt_pkg.sv
// Shared constants and types of the boundary-scan test access port.
package sbt_pkg;

  // ----------------------------------------------------------------------
  // Register widths and synchroniser depth.
  // ----------------------------------------------------------------------
  localparam int IR_W   = 3;
  localparam int ID_W   = 32;
  localparam int BSR_W  = 107;
  localparam int RD_W   = 36;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------------
  // Instruction codes.
  // ----------------------------------------------------------------------
  localparam logic [IR_W-1:0] INS_EXTEST   = 3'h0;
  localparam logic [IR_W-1:0] INS_IDCODE   = 3'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE   = 3'h4;
  localparam logic [IR_W-1:0] INS_BYPASS   = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE   = 3'h1;

  // ----------------------------------------------------------------------
  // Identification word fields. The three code values are arbitrary.
  // ----------------------------------------------------------------------
  localparam int ID_REV_LSB = 29;
  localparam int ID_DEV_LSB = 12;
  localparam int ID_VEN_LSB = 1;
  localparam logic [2:0]  ID_REVISION = 3'h1;
  localparam logic [16:0] ID_DEVICE   = 17'h00a5a;
  localparam logic [10:0] ID_VENDOR   = 11'h155;
  localparam logic        ID_PRESENT  = 1'h1;
  localparam logic [ID_W-1:0] ID_WORD = {ID_REVISION, ID_DEVICE, ID_VENDOR, ID_PRESENT};

  // ----------------------------------------------------------------------
  // Controller states.
  // ----------------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } sbt_state_t;

endpackage

// ===== common/sbt_sync_if.sv
// Carrier between a synchroniser and its user.
`timescale 1ns/1ps
interface sbt_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] din;
  logic [W-1:0] dout;

  modport sync_side (input din, output dout);
  modport user_side (output din, input dout);
endinterface

// ===== core/sbt_sync.sv
// Two-stage level synchroniser.
`timescale 1ns/1ps
module sbt_sync #(
  parameter int W = 1
) (
  input wire logic          clk,
  input wire logic          rst_n,
  sbt_sync_if.sync_side     port
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ----------------------------------------------------------------------
  // Only the second stage reads the first one.
  // ----------------------------------------------------------------------
  always_comb begin
    meta_d = port.din;
    sync_d = meta_q;
    if (!rst_n) begin
      meta_d = '0;
      sync_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign port.dout = sync_q;

endmodule

// ===== core/sbt_tap.sv
// Boundary-scan test access port with its memory read-data pad control.
`timescale 1ns/1ps
module sbt_tap (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RST_N,
  input  wire logic                      TCK,
  input  wire logic                      TMS,
  input  wire logic                      TDI,
  output      logic                      TDO,
  output      logic                      TDO_OE_N,
  input  wire logic [sbt_pkg::BSR_W-1:0] PAD_IN,
  input  wire logic [sbt_pkg::RD_W-1:0]  READ_DATA_IN,
  output      logic [sbt_pkg::RD_W-1:0]  READ_DATA_OUTPUTS,
  output      logic                      READ_DATA_OE_N
);

  // ----------------------------------------------------------------------
  // Crossings.
  // ----------------------------------------------------------------------
  sbt_sync_if #(.W(1))                  rst_if ();
  sbt_sync_if #(.W(sbt_pkg::BSR_W))     pad_if ();
  sbt_sync_if #(.W(sbt_pkg::IR_W))      ins_if ();
  sbt_sync_if #(.W(sbt_pkg::RD_W))      upd_if ();

  logic tck_rst_n;

  assign rst_if.din = RST_N;
  assign tck_rst_n  = rst_if.dout;

  sbt_sync #(.W(1)) u_rst_sync (
    .clk   (TCK),
    .rst_n (1'b1),
    .port  (rst_if.sync_side)
  );

  // Pad levels are asynchronous to TCK, so each bit is synchronised.
  assign pad_if.din = PAD_IN;

  sbt_sync #(.W(sbt_pkg::BSR_W)) u_pad_sync (
    .clk   (TCK),
    .rst_n (tck_rst_n),
    .port  (pad_if.sync_side)
  );

  sbt_sync #(.W(sbt_pkg::IR_W)) u_ins_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .port  (ins_if.sync_side)
  );

  sbt_sync #(.W(sbt_pkg::RD_W)) u_upd_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .port  (upd_if.sync_side)
  );

  // ----------------------------------------------------------------------
  // Controller state graph.
  // ----------------------------------------------------------------------
  // sixteen-state graph.
  function automatic sbt_pkg::sbt_state_t tap_next(input sbt_pkg::sbt_state_t s,
                                                    input logic tms);
    sbt_pkg::sbt_state_t n;
    case (s)
      sbt_pkg::ST_RESET:    n = tms ? sbt_pkg::ST_RESET   : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_IDLE:     n = tms ? sbt_pkg::ST_SEL_DR  : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_DR:   n = tms ? sbt_pkg::ST_SEL_IR  : sbt_pkg::ST_CAP_DR;
      sbt_pkg::ST_CAP_DR:   n = tms ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_SHIFT_DR: n = tms ? sbt_pkg::ST_EXIT1_DR : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_EXIT1_DR: n = tms ? sbt_pkg::ST_UPD_DR  : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_PAUSE_DR: n = tms ? sbt_pkg::ST_EXIT2_DR : sbt_pkg::ST_PAUSE_DR;
      sbt_pkg::ST_EXIT2_DR: n = tms ? sbt_pkg::ST_UPD_DR  : sbt_pkg::ST_SHIFT_DR;
      sbt_pkg::ST_UPD_DR:   n = tms ? sbt_pkg::ST_SEL_DR  : sbt_pkg::ST_IDLE;
      sbt_pkg::ST_SEL_IR:   n = tms ? sbt_pkg::ST_RESET   : sbt_pkg::ST_CAP_IR;
      sbt_pkg::ST_CAP_IR:   n = tms ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_SHIFT_IR: n = tms ? sbt_pkg::ST_EXIT1_IR : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_EXIT1_IR: n = tms ? sbt_pkg::ST_UPD_IR  : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_PAUSE_IR: n = tms ? sbt_pkg::ST_EXIT2_IR : sbt_pkg::ST_PAUSE_IR;
      sbt_pkg::ST_EXIT2_IR: n = tms ? sbt_pkg::ST_UPD_IR  : sbt_pkg::ST_SHIFT_IR;
      sbt_pkg::ST_UPD_IR:   n = tms ? sbt_pkg::ST_SEL_DR  : sbt_pkg::ST_IDLE;
      default:              n = sbt_pkg::ST_RESET;
    endcase
    return n;
  endfunction

  // Reserved codes fall back to the bypass path so the chain stays one bit.
  // register select.
  function automatic logic [1:0] dr_select(input logic [sbt_pkg::IR_W-1:0] ins);
    logic [1:0] sel;
    case (ins)
      sbt_pkg::INS_IDCODE:   sel = 2'h1;
      sbt_pkg::INS_EXTEST:   sel = 2'h2;
      sbt_pkg::INS_SAMPLE_Z: sel = 2'h2;
      sbt_pkg::INS_SAMPLE:   sel = 2'h2;
      default:               sel = 2'h0;
    endcase
    return sel;
  endfunction

  // ----------------------------------------------------------------------
  // Scan domain registers.
  // ----------------------------------------------------------------------
  sbt_pkg::sbt_state_t          state_q;
  sbt_pkg::sbt_state_t          state_d;
  logic [sbt_pkg::IR_W-1:0]     ir_sh_q;
  logic [sbt_pkg::IR_W-1:0]     ir_sh_d;
  logic [sbt_pkg::IR_W-1:0]     ir_q;
  logic [sbt_pkg::IR_W-1:0]     ir_d;
  logic                         byp_q;
  logic                         byp_d;
  logic [sbt_pkg::ID_W-1:0]     id_q;
  logic [sbt_pkg::ID_W-1:0]     id_d;
  logic [sbt_pkg::BSR_W-1:0]    bsr_q;
  logic [sbt_pkg::BSR_W-1:0]    bsr_d;
  logic [sbt_pkg::BSR_W-1:0]    upd_q;
  logic [sbt_pkg::BSR_W-1:0]    upd_d;
  logic [1:0]                   sel;

  assign sel = dr_select(ir_q);

  always_comb begin
    state_d = tap_next(state_q, TMS);
    ir_sh_d = ir_sh_q;
    ir_d    = ir_q;
    byp_d   = byp_q;
    id_d    = id_q;
    bsr_d   = bsr_q;
    upd_d   = upd_q;
    case (state_q)
      sbt_pkg::ST_CAP_DR: begin
        byp_d = 1'b0;
        id_d  = sbt_pkg::ID_WORD;
        bsr_d = pad_if.dout;
      end
      sbt_pkg::ST_SHIFT_DR: begin
        case (sel)
          2'h1:    id_d  = {TDI, id_q[sbt_pkg::ID_W-1:1]};
          2'h2:    bsr_d = {TDI, bsr_q[sbt_pkg::BSR_W-1:1]};
          default: byp_d = TDI;
        endcase
      end
      sbt_pkg::ST_UPD_DR: begin
        if (sel == 2'h2) begin
          upd_d = bsr_q;
        end
      end
      sbt_pkg::ST_CAP_IR: begin
        ir_sh_d = sbt_pkg::IR_CAPTURE;
      end
      sbt_pkg::ST_SHIFT_IR: begin
        ir_sh_d = {TDI, ir_sh_q[sbt_pkg::IR_W-1:1]};
      end
      sbt_pkg::ST_UPD_IR: begin
        ir_d = ir_sh_q;
        if (ir_sh_q == sbt_pkg::INS_BYPASS) begin
          byp_d = 1'b0;
        end
      end
      sbt_pkg::ST_RESET: begin
        ir_d = sbt_pkg::INS_IDCODE;
      end
      default: begin
        ir_d = ir_q;
      end
    endcase
    if (!tck_rst_n) begin
      state_d = sbt_pkg::ST_RESET;
      ir_sh_d = sbt_pkg::IR_CAPTURE;
      ir_d    = sbt_pkg::INS_IDCODE;
      byp_d   = 1'b0;
      id_d    = sbt_pkg::ID_WORD;
      bsr_d   = '0;
      upd_d   = '0;
    end
  end

  always_ff @(posedge TCK) begin
    state_q <= state_d;
    ir_sh_q <= ir_sh_d;
    ir_q    <= ir_d;
    byp_q   <= byp_d;
    id_q    <= id_d;
    bsr_q   <= bsr_d;
    upd_q   <= upd_d;
  end

  // ----------------------------------------------------------------------
  // Serial output on the falling edge.
  // ----------------------------------------------------------------------
  logic tdo_q;
  logic tdo_d;
  logic tdo_oe_n_q;
  logic tdo_oe_n_d;

  always_comb begin
    tdo_d      = tdo_q;
    tdo_oe_n_d = 1'b1;
    if (state_q == sbt_pkg::ST_SHIFT_IR) begin
      tdo_d      = ir_sh_q[0];
      tdo_oe_n_d = 1'b0;
    end else if (state_q == sbt_pkg::ST_SHIFT_DR) begin
      tdo_oe_n_d = 1'b0;
      case (sel)
        2'h1:    tdo_d = id_q[0];
        2'h2:    tdo_d = bsr_q[0];
        default: tdo_d = byp_q;
      endcase
    end
    if (!tck_rst_n) begin
      tdo_d      = 1'b0;
      tdo_oe_n_d = 1'b1;
    end
  end

  always_ff @(negedge TCK) begin
    tdo_q      <= tdo_d;
    tdo_oe_n_q <= tdo_oe_n_d;
  end

  assign TDO      = tdo_q;
  assign TDO_OE_N = tdo_oe_n_q;

  // ----------------------------------------------------------------------
  // Core domain pad control.
  // ----------------------------------------------------------------------
  // The synchroniser clears to zero, so the code crosses relative to the reset
  // instruction; a cleared stage then reads as the identification code, not extest.
  assign ins_if.din = ir_q ^ sbt_pkg::INS_IDCODE;
  assign upd_if.din = upd_q[sbt_pkg::RD_W-1:0];

  logic [sbt_pkg::IR_W-1:0] ins_rx;
  logic [sbt_pkg::IR_W-1:0] ins_last_q;
  logic [sbt_pkg::IR_W-1:0] ins_last_d;
  logic [sbt_pkg::IR_W-1:0] ins_q;
  logic [sbt_pkg::IR_W-1:0] ins_d;
  logic [sbt_pkg::RD_W-1:0] upd_last_q;
  logic [sbt_pkg::RD_W-1:0] upd_last_d;
  logic [sbt_pkg::RD_W-1:0] upd_hold_q;
  logic [sbt_pkg::RD_W-1:0] upd_hold_d;
  logic [sbt_pkg::RD_W-1:0] rd_q;
  logic [sbt_pkg::RD_W-1:0] rd_d;
  logic                     rd_oe_n_q;
  logic                     rd_oe_n_d;

  assign ins_rx = ins_if.dout ^ sbt_pkg::INS_IDCODE;

  // A multi-bit code may arrive skewed, so it is taken only once stable.
  always_comb begin
    ins_last_d = ins_rx;
    ins_d      = ins_q;
    if (ins_rx == ins_last_q) begin
      ins_d = ins_last_q;
    end
    upd_last_d = upd_if.dout;
    upd_hold_d = upd_hold_q;
    if (upd_if.dout == upd_last_q) begin
      upd_hold_d = upd_last_q;
    end
    rd_d      = READ_DATA_IN;
    rd_oe_n_d = 1'b0;
    case (ins_q)
      sbt_pkg::INS_SAMPLE_Z: rd_oe_n_d = 1'b1;
      sbt_pkg::INS_EXTEST:   rd_d      = upd_hold_q;
      default:               rd_oe_n_d = 1'b0;
    endcase
    if (!RST_N) begin
      ins_last_d = sbt_pkg::INS_IDCODE;
      ins_d      = sbt_pkg::INS_IDCODE;
      upd_last_d = '0;
      upd_hold_d = '0;
      rd_d       = '0;
      rd_oe_n_d  = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    ins_last_q <= ins_last_d;
    ins_q      <= ins_d;
    upd_last_q <= upd_last_d;
    upd_hold_q <= upd_hold_d;
    rd_q       <= rd_d;
    rd_oe_n_q  <= rd_oe_n_d;
  end

  assign READ_DATA_OUTPUTS = rd_q;
  assign READ_DATA_OE_N    = rd_oe_n_q;

endmodule

// ===== test/sbt_tap_checker.sv
// Checker of the boundary-scan port and its read-data pad control.
`timescale 1ns/1ps
module sbt_tap_checker (
  input wire logic                     CORE_CLK,
  input wire logic                     RST_N,
  input wire logic                     TCK,
  input wire logic                     TMS,
  input wire logic                     TDO,
  input wire logic                     TDO_OE_N,
  input wire logic [sbt_pkg::RD_W-1:0] READ_DATA_IN,
  input wire logic [sbt_pkg::RD_W-1:0] READ_DATA_OUTPUTS,
  input wire logic                     READ_DATA_OE_N
);
  logic       tck_q;
  logic       tck_d;
  logic       used_q;
  logic       used_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  // The age of the last TCK rise bounds how late an instruction may reach the pads.
  always_comb begin
    tck_d  = TCK;
    used_d = RST_N & (used_q | (TCK & ~tck_q));
    cnt_d  = (TCK & ~tck_q) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
  end
  always_ff @(posedge CORE_CLK) begin
    tck_q  <= tck_d;
    used_q <= used_d;
    cnt_q  <= cnt_d;
  end
  AST_TDO_HOLD: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    TCK && $past(TCK) |-> $stable(TDO) && $stable(TDO_OE_N)) else $error("TDO moved, TCK high");
  AST_TLR_FLOAT: assert property (
    @(posedge TCK) disable iff (!RST_N) TMS [*5] |=> TDO_OE_N) else $error("TDO driven in reset");
  AST_EXIT_FLOAT: assert property (
    @(posedge TCK) disable iff (!RST_N) TMS |=> TDO_OE_N) else $error("TDO driven off shift");
  AST_RST_FLOAT: assert property (
    @(posedge TCK) !RST_N [*5] |-> TDO_OE_N && !TDO) else $error("TDO not idle in reset");
  AST_SHIFT_ENTRY: assert property (
    @(posedge TCK) disable iff (!RST_N)
    $fell(TDO_OE_N) |-> !$past(TMS) && !$past(TMS, 2)) else $error("TDO driven too early");
  AST_CORE_RST: assert property (
    @(posedge CORE_CLK) !RST_N |=> READ_DATA_OUTPUTS == '0 && !READ_DATA_OE_N)
    else $error("read pads not reset");
  AST_PASS: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N) !used_q && $past(RST_N)
    |-> READ_DATA_OUTPUTS == $past(READ_DATA_IN) && !READ_DATA_OE_N) else $error("read path broken");
  AST_OE_CAUSE: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    $changed(READ_DATA_OE_N) |-> cnt_q >= 4'h2 && cnt_q <= 4'h8) else $error("pad enable moved");
endmodule
bind sbt_tap sbt_tap_checker i_sbt_tap_checker (.CORE_CLK, .RST_N, .TCK, .TMS, .TDO, .TDO_OE_N,
  .READ_DATA_IN, .READ_DATA_OUTPUTS, .READ_DATA_OE_N);

// ===== test/sbt_tester.sv
// Model of the external serial test controller.
`timescale 1ns/1ps
module sbt_tester (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  logic tdo_s;
  logic oe_s;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #61.5;
    tdo_s = tdo;
    oe_s  = tdo_oe_n;
    tck   = 1'b1;
    #62.5;
    tck = 1'b0;
    #1;
  endtask
endmodule

// ===== test/tb_sbt_tap.sv
// Self-checking bench of the boundary-scan port.
`timescale 1ns/1ps
module tb_sbt_tap;
  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         tdo;
  logic         tdo_oe_n;
  logic         rd_oe_n;
  logic [106:0] pad_in = '0;
  logic [106:0] w;
  logic [106:0] q;
  logic [35:0]  rd_in = '0;
  logic [35:0]  rd_prev;
  logic [35:0]  rd_out;
  int           err_count = 0;
  int           n_tests = 0;
  int           cyc = 0;
  integer       seed = 32'hca3b;

  sbt_tap i_sbt_tap (
    .CORE_CLK          (core_clk),
    .RST_N             (rst_n),
    .TCK               (tck),
    .TMS               (tms),
    .TDI               (tdi),
    .TDO               (tdo),
    .TDO_OE_N          (tdo_oe_n),
    .PAD_IN            (pad_in),
    .READ_DATA_IN      (rd_in),
    .READ_DATA_OUTPUTS (rd_out),
    .READ_DATA_OE_N    (rd_oe_n)
  );
  sbt_tester i_sbt_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    rd_prev <= rd_in;
    #1 rd_in = 36'({$random(seed), $random(seed)});
  end
  // The run is about 17000 cycles; the ceiling leaves room for slow settling.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      results();
    end
  end

  task automatic check(input logic [106:0] s, input logic [106:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [106:0] exp_dr(input int c, input logic [106:0] d,
                                           input logic [106:0] p);
    logic [138:0] t;
    t = {d, sbt_pkg::ID_WORD};
    if (c == 1)
      return t[106:0];
    if (c == 0 || c == 2 || c == 4)
      return p;
    return {d[105:0], 1'b0};
  endfunction

  // Walks from idle through one shift and back to idle, least significant bit first.
  task automatic scan(input logic ir, input logic [106:0] d, input int n,
                      output logic [106:0] r);
    logic z;
    r = '0;
    z = 1'b0;
    i_sbt_tester.step(1'b1, 1'b1);
    if (ir)
      i_sbt_tester.step(1'b1, 1'b1);
    i_sbt_tester.step(1'b0, 1'b1);
    i_sbt_tester.step(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_sbt_tester.step(1'(i == n - 1), d[i]);
      r[i] = i_sbt_tester.tdo_s;
      z = z | i_sbt_tester.oe_s;
    end
    i_sbt_tester.step(1'b1, 1'b1);
    check(107'(z), 107'h0);
    check(107'(i_sbt_tester.oe_s), 107'h1);
    i_sbt_tester.step(1'b0, 1'b1);
  endtask

  initial begin
    repeat (6) i_sbt_tester.step(1'b1, 1'b1);
    @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (3) i_sbt_tester.step(1'b1, 1'b1);
    i_sbt_tester.step(1'b0, 1'b1);
    $display("reset test done");
    for (int c = 0; c < 8; c++) begin
      @(posedge core_clk);
      #1 pad_in = 107'({$random(seed), $random(seed), $random(seed), $random(seed)});
      w = 107'({$random(seed), $random(seed), $random(seed), $random(seed)});
      scan(1'b1, 107'(c), 3, q);
      check(q, 107'(sbt_pkg::IR_CAPTURE));
      scan(1'b0, w, 107, q);
      check(q, exp_dr(c, w, pad_in));
      repeat (6) @(posedge core_clk);
      #2;
      check(107'(rd_oe_n), 107'(c == 2));
      if (c != 2)
        check(107'(rd_out), 107'(c == 0 ? w[35:0] : rd_prev));
      $display("test code %0d done", c);
    end
    // Five high TMS clocks from idle must alone restore the identification path.
    repeat (5) i_sbt_tester.step(1'b1, 1'b1);
    i_sbt_tester.step(1'b0, 1'b1);
    scan(1'b0, w, 32, q);
    check(q, 107'(sbt_pkg::ID_WORD));
    $display("tms reset test done");
    // A mid-run reset with TMS low must alone restore the identification path.
    scan(1'b1, 107'(sbt_pkg::INS_BYPASS), 3, q);
    @(posedge core_clk);
    #1 rst_n = 1'b0;
    repeat (6) i_sbt_tester.step(1'b0, 1'b1);
    @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (3) i_sbt_tester.step(1'b0, 1'b1);
    scan(1'b0, w, 32, q);
    check(q, 107'(sbt_pkg::ID_WORD));
    $display("mid-run reset test done");
    results();
  end
endmodule
